// ===== verilog/pgsf_flags.sv
// Global event flags and live status register bank of the power manager
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - soft_control_field write 0b10 sets bit 4
// - manual reset sets bit 3 until read
// - undervoltage sets bit 2, overvoltage bit 1
// - thermal overload sets bit 0 until read
// - flags reset to 0, a fault-cause read clears all but events present in the read cycle
// - status bit 7 is factory device id
// - status bit 6 shows bias ready, resets 1
// - status bit 5 shows LDO A dropout
// - status bit 4 shows LDO B dropout
// - status bit 3 shows thermal alarm two
// - status bit 2 shows thermal alarm one
// - status bit 1 shows debounced enable active
// - status bit 0 shows unmasked interrupt gate
// - gate bit mirrors open-drain interrupt drive
module pgsf_flags #(
  parameter int DEBOUNCE_CYCLES = pgsf_pkg::PGSF_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Register access from the serial interface engine
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  // Event detectors (asynchronous levels)
  input  wire logic       i_manual_reset_evt,
  input  wire logic       i_sys_undervolt_evt,
  input  wire logic       i_sys_overvolt_evt,
  input  wire logic       i_thermal_overload_evt,
  // Live status sources (asynchronous levels)
  input  wire logic       i_device_id_bit,
  input  wire logic       i_bias_ready,
  input  wire logic       i_ldo_a_dropout,
  input  wire logic       i_ldo_b_dropout,
  input  wire logic       i_thermal_alarm_two,
  input  wire logic       i_thermal_alarm_one,
  input  wire logic       i_enable_input_n,
  // Unmasked interrupt gate drive (same clock)
  input  wire logic       i_irq_gate,
  // Soft power-off command to the sequencer
  output logic            o_soft_poweroff
);

  import pgsf_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [PGSF_SYNC_W-1:0] sync_bus;
  logic                   id_s;
  logic                   bias_s;
  logic                   ldo_a_s;
  logic                   ldo_b_s;
  logic                   alarm2_s;
  logic                   alarm1_s;
  logic                   enable_n_s;
  logic                   man_rst_s;
  logic                   uv_s;
  logic                   ov_s;
  logic                   tovl_s;

  pgsf_sync #(
    .WIDTH     (PGSF_SYNC_W),
    .RESET_VAL (PGSF_SYNC_RESET)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_device_id_bit, i_bias_ready, i_ldo_a_dropout, i_ldo_b_dropout,
                  i_thermal_alarm_two, i_thermal_alarm_one, i_enable_input_n,
                  i_manual_reset_evt, i_sys_undervolt_evt, i_sys_overvolt_evt,
                  i_thermal_overload_evt}),
    .o_sync     (sync_bus)
  );

  // Split the synchronised lanes
  assign {id_s, bias_s, ldo_a_s, ldo_b_s, alarm2_s, alarm1_s, enable_n_s,
          man_rst_s, uv_s, ov_s, tovl_s} = sync_bus;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic rd_fault;
  logic rd_status;
  logic wr_poweroff;

  // Register selects
  assign rd_fault    = i_reg_rd && (i_reg_addr == PGSF_ADDR_FAULT_CAUSE);
  assign rd_status   = i_reg_rd && (i_reg_addr == PGSF_ADDR_GLOBAL_STAT);
  assign wr_poweroff = i_reg_wr && (i_reg_addr == PGSF_ADDR_SOFT_CTRL) &&
                       (i_reg_wdata[PGSF_SFT_LSB +: 2] == PGSF_SFT_POWEROFF);

  // ----------------------------------------------------------------
  // Enable input debounce
  // ----------------------------------------------------------------
  logic [PGSF_DEBOUNCE_W-1:0] deb_cnt;
  logic                       enable_active;

  // Flip the debounced state only after the new level held long enough
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      deb_cnt       <= '0;
      enable_active <= 1'b0;
    end else if (enable_active == enable_n_s) begin
      if (deb_cnt == PGSF_DEBOUNCE_W'(DEBOUNCE_CYCLES - 1)) begin
        deb_cnt       <= '0;
        enable_active <= ~enable_n_s;
      end else begin
        deb_cnt <= deb_cnt + 1'b1;
      end
    end else begin
      deb_cnt <= '0;  // Bounce restarts the wait
    end
  end

  // ----------------------------------------------------------------
  // Fault-cause event flags
  // ----------------------------------------------------------------
  logic [7:0] fault_flags;
  logic [7:0] fault_set;
  logic [7:0] next_fault_flags;

  // New events this cycle; a set always beats a read clear
  always_comb begin
    fault_set                        = 8'h00;
    fault_set[PGSF_FC_SOFT_POWEROFF] = wr_poweroff;
    fault_set[PGSF_FC_MANUAL_RESET]  = man_rst_s;
    fault_set[PGSF_FC_SYS_UNDERVOLT] = uv_s;
    fault_set[PGSF_FC_SYS_OVERVOLT]  = ov_s;
    fault_set[PGSF_FC_THERM_OVLD]    = tovl_s;
    next_fault_flags = (rd_fault ? 8'h00 : fault_flags) | fault_set;
  end

  // Flag storage
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      fault_flags <= PGSF_FC_RESET;
    end else begin
      fault_flags <= next_fault_flags;
    end
  end

  // ----------------------------------------------------------------
  // Live global status word
  // ----------------------------------------------------------------
  logic [7:0] global_status;

  // Assembled from present source levels, never latched
  always_comb begin
    global_status                     = 8'h00;
    global_status[PGSF_GS_DEVICE_ID]  = id_s;
    global_status[PGSF_GS_BIAS_READY] = bias_s;
    global_status[PGSF_GS_LDO_A_DROP] = ldo_a_s;
    global_status[PGSF_GS_LDO_B_DROP] = ldo_b_s;
    global_status[PGSF_GS_THERM_TWO]  = alarm2_s;
    global_status[PGSF_GS_THERM_ONE]  = alarm1_s;
    global_status[PGSF_GS_ENABLE]     = enable_active;
    global_status[PGSF_GS_IRQ_GATE]   = i_irq_gate;
  end

  // ----------------------------------------------------------------
  // Read data and command outputs
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  // Read mux; writes never reach the status word
  always_comb begin
    next_rdata = 8'h00;
    if (rd_fault) begin
      next_rdata = fault_flags;
    end else if (rd_status) begin
      next_rdata = global_status;
    end
  end

  // Registered read data, valid one cycle after the read strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // One-cycle power-off command to the sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_soft_poweroff <= 1'b0;
    end else begin
      o_soft_poweroff <= wr_poweroff;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_poweroff_set;
    wr_poweroff ##1 !i_reg_rd ##1 rd_fault
      |=> o_reg_rdata[PGSF_FC_SOFT_POWEROFF] && o_soft_poweroff == 1'b0;
  endproperty
  a_poweroff_set: assert property (p_poweroff_set)
    else $error("soft power-off flag not reported");

  property p_manual_set;
    man_rst_s |=> fault_flags[PGSF_FC_MANUAL_RESET];
  endproperty
  a_manual_set: assert property (p_manual_set)
    else $error("manual reset flag not set");

  property p_volt_set;
    (uv_s || ov_s) |=> (fault_flags[PGSF_FC_SYS_UNDERVOLT] || !$past(uv_s)) &&
                      (fault_flags[PGSF_FC_SYS_OVERVOLT] || !$past(ov_s));
  endproperty
  a_volt_set: assert property (p_volt_set)
    else $error("system rail flag not set");

  property p_tovl_hold;
    fault_flags[PGSF_FC_THERM_OVLD] && !rd_fault |=> fault_flags[PGSF_FC_THERM_OVLD];
  endproperty
  a_tovl_hold: assert property (p_tovl_hold)
    else $error("thermal overload flag dropped without read");

  property p_read_clear;
    rd_fault && fault_set == 8'h00 |=> fault_flags == 8'h00 &&
                                       o_reg_rdata == $past(fault_flags) && o_reg_rvalid;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("fault read did not report and clear");

  property p_status_live;
    rd_status |=> o_reg_rdata[7:2] == $past({id_s, bias_s, ldo_a_s, ldo_b_s, alarm2_s, alarm1_s});
  endproperty
  a_status_live: assert property (p_status_live)
    else $error("status sources misreported");

  property p_gate_mirror;
    rd_status |=> o_reg_rdata[PGSF_GS_IRQ_GATE] == $past(i_irq_gate) &&
                  o_reg_rdata[PGSF_GS_ENABLE] == $past(enable_active);
  endproperty
  a_gate_mirror: assert property (p_gate_mirror)
    else $error("gate or enable status misreported");

  property p_debounce_wait;
    $changed(enable_active) |-> $past(enable_n_s) != enable_active &&
                                $past(deb_cnt) == PGSF_DEBOUNCE_W'(DEBOUNCE_CYCLES - 1);
  endproperty
  a_debounce_wait: assert property (p_debounce_wait)
    else $error("enable changed before debounce time");

  property p_no_side_effect;
    (rd_status || (i_reg_wr && i_reg_addr == PGSF_ADDR_GLOBAL_STAT)) && fault_set == 8'h00
      |=> $stable(fault_flags);
  endproperty
  a_no_side_effect: assert property (p_no_side_effect)
    else $error("status access disturbed fault flags");

  property p_poweroff_pulse;
    wr_poweroff |=> o_soft_poweroff && fault_flags[PGSF_FC_SOFT_POWEROFF];
  endproperty
  a_poweroff_pulse: assert property (p_poweroff_pulse)
    else $error("power-off write left no command or flag");

  property p_poweroff_cause;
    o_soft_poweroff |-> $past(wr_poweroff);
  endproperty
  a_poweroff_cause: assert property (p_poweroff_cause)
    else $error("power-off command without a matching write");

  property p_rvalid_pulse;
    1'b1 |=> o_reg_rvalid == $past(i_reg_rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("read valid not one cycle after strobe");

  property p_rdata_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_set_beats_clear;
    rd_fault && fault_set != 8'h00 |=> (fault_flags & $past(fault_set)) == $past(fault_set);
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("event in read cycle was lost");

  c_fault_read: cover property (rd_fault && fault_flags != 8'h00);
  c_poweroff: cover property (wr_poweroff);
  c_set_on_clear: cover property (rd_fault && fault_set != 8'h00);
  c_enable_on: cover property ($rose(enable_active));
  c_status_write: cover property (i_reg_wr && i_reg_addr == PGSF_ADDR_GLOBAL_STAT);

endmodule

`default_nettype wire

// ===== verilog/pgsf_pkg.sv
// Package: offsets, field positions, reset values and timing for the status flag bank
`default_nettype none

package pgsf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PGSF_ADDR_FAULT_CAUSE = 8'h04;  // Read-clear event flags
  localparam logic [7:0] PGSF_ADDR_SOFT_CTRL   = 8'h05;  // Write decodes soft_control_field, not stored
  localparam logic [7:0] PGSF_ADDR_GLOBAL_STAT = 8'h06;  // global_status, read only

  // ----------------------------------------------------------------
  // Fault-cause register bit positions
  // ----------------------------------------------------------------
  localparam int PGSF_FC_SOFT_POWEROFF = 4;
  localparam int PGSF_FC_MANUAL_RESET  = 3;
  localparam int PGSF_FC_SYS_UNDERVOLT = 2;
  localparam int PGSF_FC_SYS_OVERVOLT  = 1;
  localparam int PGSF_FC_THERM_OVLD    = 0;
  localparam logic [7:0] PGSF_FC_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Soft control field: position and command codes
  // ----------------------------------------------------------------
  localparam int PGSF_SFT_LSB = 0;
  localparam logic [1:0] PGSF_SFT_POWEROFF = 2'h2;

  // ----------------------------------------------------------------
  // Global status bit positions
  // ----------------------------------------------------------------
  localparam int PGSF_GS_DEVICE_ID  = 7;
  localparam int PGSF_GS_BIAS_READY = 6;
  localparam int PGSF_GS_LDO_A_DROP = 5;
  localparam int PGSF_GS_LDO_B_DROP = 4;
  localparam int PGSF_GS_THERM_TWO  = 3;
  localparam int PGSF_GS_THERM_ONE  = 2;
  localparam int PGSF_GS_ENABLE     = 1;
  localparam int PGSF_GS_IRQ_GATE   = 0;

  // ----------------------------------------------------------------
  // Synchroniser lanes and their reset values
  // ----------------------------------------------------------------
  localparam int PGSF_SYNC_W = 11;
  // Lanes: 10 id, 9 bias, 8 ldo a, 7 ldo b, 6 alarm2, 5 alarm1,
  //        4 enable_n, 3 manual rst, 2 uv, 1 ov, 0 thermal overload
  localparam logic [10:0] PGSF_SYNC_RESET = 11'h210;  // Bias ready 1, enable_n idle high

  // ----------------------------------------------------------------
  // Enable input debounce timing
  // ----------------------------------------------------------------
  localparam int PGSF_CLK_PERIOD_NS   = 25;
  localparam int PGSF_DEBOUNCE_NS     = 100000;
  localparam int PGSF_DEBOUNCE_CYCLES =
    (PGSF_DEBOUNCE_NS + PGSF_CLK_PERIOD_NS - 1) / PGSF_CLK_PERIOD_NS;
  localparam int PGSF_DEBOUNCE_W      = 12;

endpackage

`default_nettype wire

// ===== verilog/pgsf_sync.sv
// Two-flop synchroniser bank for asynchronous detector and pin levels
`timescale 1ns/1ps
`default_nettype none

module pgsf_sync #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  // Levels in and out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // One two-stage chain per lane; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
      always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
          meta[g]   <= RESET_VAL[g];
          o_sync[g] <= RESET_VAL[g];
        end else begin
          meta[g]   <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== tb/pgsf_host_model.sv
// Host processor model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none

module pgsf_host_model (
  // Clock
  input  wire logic       i_core_clk,
  // Register access towards the flag bank
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid
);
  // Idle bus at time zero
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // One-cycle write strobe, changed only at falling edges
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_core_clk);
    o_reg_addr  = addr;
    o_reg_wdata = data;
    o_reg_wr    = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~data;  // Stale data does not linger on the bus
  endtask

  // One-cycle read strobe; data taken only with the valid pulse
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_core_clk);
    o_reg_addr = addr;
    o_reg_rd   = 1'b1;
    @(negedge i_core_clk);
    o_reg_rd   = 1'b0;
    data       = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hXX;
  endtask
endmodule

`default_nettype wire

// ===== tb/pgsf_flags_tb.sv
// Self-checking bench for the global status flag bank
`timescale 1ns/1ps
`default_nettype none

module pgsf_flags_tb;
  import pgsf_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic [3:0] ev;       // Manual reset, undervolt, overvolt, overload
  logic [7:0] src;      // Live sources in global_status bit order
  logic       poweroff;
  logic [7:0] got;
  int         n_mismatch;
  int         checks_done;

  // Clock generation
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  pgsf_flags #(.DEBOUNCE_CYCLES(4)) i_dut (
    .i_core_clk            (clk),
    .i_rst_n               (rst_n),
    .i_reg_addr            (addr),
    .i_reg_wr              (wr),
    .i_reg_rd              (rd),
    .i_reg_wdata           (wdata),
    .o_reg_rdata           (rdata),
    .o_reg_rvalid          (rvalid),
    .i_manual_reset_evt    (ev[3]),
    .i_sys_undervolt_evt   (ev[2]),
    .i_sys_overvolt_evt    (ev[1]),
    .i_thermal_overload_evt(ev[0]),
    .i_device_id_bit       (src[7]),
    .i_bias_ready          (src[6]),
    .i_ldo_a_dropout       (src[5]),
    .i_ldo_b_dropout       (src[4]),
    .i_thermal_alarm_two   (src[3]),
    .i_thermal_alarm_one   (src[2]),
    .i_enable_input_n      (~src[1]),
    .i_irq_gate            (src[0]),
    .o_soft_poweroff       (poweroff)
  );

  pgsf_host_model i_host (
    .i_core_clk  (clk),
    .o_reg_addr  (addr),
    .o_reg_wr    (wr),
    .o_reg_rd    (rd),
    .o_reg_wdata (wdata),
    .i_reg_rdata (rdata),
    .i_reg_rvalid(rvalid)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait a number of falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Print verdict and stop
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Values straight after reset, and an unmapped read
  task automatic t_reset_values();
    check({7'h00, poweroff}, 8'h00);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, PGSF_FC_RESET);
    i_host.rd(PGSF_ADDR_GLOBAL_STAT, got);
    check(got, src);
    i_host.rd(8'h07, got);
    check(got, 8'h00);
  endtask

  // Every soft control code; only the power-off code leaves a trace
  task automatic t_soft_codes();
    for (int c = 0; c < 4; c++) begin
      i_host.wr(PGSF_ADDR_SOFT_CTRL, 8'(c));
      check({7'h00, poweroff}, {7'h00, c == 2});
      idle(1);
      check({7'h00, poweroff}, 8'h00);
      i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
      check(got, (c == 2) ? 8'h10 : 8'h00);
    end
  endtask

  // Each detector alone, then several together with a power-off
  task automatic t_events();
    for (int i = 0; i < 4; i++) begin
      ev[i] = 1'b1;
      idle(2);
      ev[i] = 1'b0;
      idle(4);
      i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
      check(got, 8'h01 << i);
      i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
      check(got, 8'h00);
    end
    ev = 4'hA;
    i_host.wr(PGSF_ADDR_SOFT_CTRL, 8'h02);
    ev = 4'h0;
    idle(4);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, 8'h1A);
  endtask

  // Each live source toggled, read twice around an ignored write
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      src[i] = ~src[i];
      idle(12);
      i_host.rd(PGSF_ADDR_GLOBAL_STAT, got);
      check(got, src);
      i_host.wr(PGSF_ADDR_GLOBAL_STAT, ~src);
      i_host.rd(PGSF_ADDR_GLOBAL_STAT, got);
      check(got, src);
      src[i] = ~src[i];
      idle(12);
      i_host.rd(PGSF_ADDR_GLOBAL_STAT, got);
      check(got, src);
    end
  endtask

  // A detector held high re-arms its flag across reads; set beats clear
  task automatic t_level_hold();
    ev[2] = 1'b1;
    idle(4);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, 8'h04);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, 8'h04);
    ev[2] = 1'b0;
    idle(4);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, 8'h04);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, 8'h00);
  endtask

  // Reset in mid-run drops pending flags and restores idle outputs
  task automatic t_mid_reset();
    ev[0] = 1'b1;
    i_host.wr(PGSF_ADDR_SOFT_CTRL, 8'h02);
    ev[0] = 1'b0;
    idle(2);
    rst_n = 1'b0;
    idle(6);
    rst_n = 1'b1;
    check({7'h00, poweroff}, 8'h00);
    i_host.rd(PGSF_ADDR_FAULT_CAUSE, got);
    check(got, PGSF_FC_RESET);
    i_host.rd(PGSF_ADDR_GLOBAL_STAT, got);
    check(got, src);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    ev          = 4'h0;
    src         = 8'hC0;
    n_mismatch  = 0;
    checks_done = 0;
    idle(6);
    rst_n = 1'b1;
    t_reset_values();
    t_soft_codes();
    t_events();
    t_status();
    t_level_hold();
    t_mid_reset();
    conclude();
  end

  // Cut a hang short well beyond the expected run
  initial begin
    #(25 * 20000);
    n_mismatch++;
    conclude();
  end
endmodule

`default_nettype wire
